// *** core/tmc_timer.sv ***
// Timer control: AHB-Lite registers, mode decode, counter and capture.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module tmc_timer
   import tmc_pkg::*;
(
   input  wire logic        hclk,                 // Bus clock, 10 MHz.
   input  wire logic        hresetn,              // Async reset, low.
   input  wire logic        hsel,                 // Slave select.
   input  wire logic [31:0] haddr,                // Byte address.
   input  wire logic [1:0]  htrans,               // Transfer type.
   input  wire logic        hwrite,               // Write when high.
   input  wire logic [2:0]  hsize,                // Word only.
   input  wire logic [31:0] hwdata,               // Write data.
   input  wire logic        hready,               // Bus ready.
   output logic             hreadyout,            // Always ready.
   output logic             hresp,                // Always OKAY.
   output logic [31:0]      hrdata,               // Read data.
   input  wire logic        capture_input_pin,    // Capture input.
   input  wire logic        external_count_pin,   // External count.
   output logic             irq,                  // Level interrupt.
   output logic             wave_evt_a,           // Channel A match.
   output logic             wave_evt_b,           // Channel B match.
   output logic [1:0]       compare_output_mode_a, // Channel A action.
   output logic [1:0]       compare_output_mode_b, // Channel B action.
   output logic [15:0]      counter_value,        // Counter.
   output logic [3:0]       wave_mode_sel         // Joined mode select.
);
   typedef struct packed {
      logic [7:0]      wave;
      logic [7:0]      capclk;
      logic [15:0]     cnt;
      tmc_dir_t        dir;
      logic [15:0]     icr;
      logic [15:0]     ocra_buf;
      logic [15:0]     ocra;
      logic [15:0]     ocrb_buf;
      logic [15:0]     ocrb;
      logic [7:0]      temp;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      logic            block;
      logic            dph_wr;
      logic            dph_rd;
      logic [7:0]      dph_idx;
      logic            evt_a;
      logic            evt_b;
   } tmc_state_t;

   tmc_state_t      s_q;
   tmc_state_t      s_d;
   tmc_mode_t       md;
   logic [15:0]     top;
   logic            tick;
   logic            cap_raw;
   logic            cap_evt;
   logic            match_a;
   logic            match_b;
   logic            force_a;
   logic            force_b;
   logic            at_top;
   logic            at_bot;
   logic            upd_now;
   logic            ovf_now;
   logic [7:0]      wd;
   logic [7:0]      rd;
   logic [ST_W-1:0] st_set;
   logic [ST_W-1:0] st_clr;

   tmc_prescale u_prescale (
      .hclk               (hclk),
      .hresetn            (hresetn),
      .count_clock_sel    (s_q.capclk[2:0]),
      .external_count_pin (external_count_pin),
      .tick               (tick)
   );

   tmc_capfilt #(.LEN(FILTER_LEN)) u_capfilt (
      .hclk              (hclk),
      .hresetn           (hresetn),
      .capture_input_pin (capture_input_pin),
      .filter_en         (s_q.capclk[FLD_FILTER_EN]),
      .edge_sel          (s_q.capclk[FLD_EDGE_SEL]),
      .cap_evt           (cap_raw)
   );

   assign wave_mode_sel = {s_q.capclk[4:3], s_q.wave[1:0]};
   assign md            = tmc_decode(wave_mode_sel);
   assign wd            = hwdata[7:0];

   always_comb begin
      case (md.src)
         TOP_CMPA: top = s_q.ocra;
         TOP_CAP:  top = s_q.icr;
         default:  top = md.fixed_top;
      endcase
   end

   // The pin is ignored while the capture register is the TOP value.
   assign cap_evt = cap_raw && (md.src != TOP_CAP);
   assign at_top  = s_q.cnt == top;
   assign at_bot  = s_q.cnt == CNT_BOTTOM;
   assign match_a = tick && !s_q.block && s_q.cnt == s_q.ocra;
   assign match_b = tick && !s_q.block && s_q.cnt == s_q.ocrb;
   assign force_a = s_q.dph_wr && s_q.dph_idx == IDX_FORCE
                    && wd[FLD_FORCE_A] && !md.pwm;
   assign force_b = s_q.dph_wr && s_q.dph_idx == IDX_FORCE
                    && wd[FLD_FORCE_B] && !md.pwm;

   always_comb begin
      case (md.upd)
         AT_TOP:    upd_now = tick && at_top;
         AT_BOTTOM: upd_now = tick && at_bot;
         default:   upd_now = 1'b1;
      endcase
      case (md.ovf)
         AT_TOP:    ovf_now = tick && at_top;
         AT_BOTTOM: ovf_now = tick && at_bot && s_q.dir == DIR_DOWN;
         default:   ovf_now = tick && s_q.cnt == CNT_MAX;
      endcase
   end

   always_comb begin
      st_set          = '0;
      st_set[ST_OVF]  = ovf_now;
      st_set[ST_CMPA] = match_a;
      st_set[ST_CMPB] = match_b;
      st_set[ST_CAP]  = cap_evt;
      st_clr          = '0;
      if (s_q.dph_wr && s_q.dph_idx == IDX_STATUS)
         st_clr = wd[ST_W-1:0];
   end

   always_comb begin
      s_d        = s_q;
      s_d.evt_a  = match_a || force_a;
      s_d.evt_b  = match_b || force_b;
      s_d.dph_wr = hsel && htrans[1] && hready && hwrite;
      s_d.dph_rd = hsel && htrans[1] && hready && !hwrite;
      if (hsel && htrans[1] && hready)
         s_d.dph_idx = haddr[9:2];
      if (tick) begin
         s_d.block = 1'b0;
         // Forced matches never reach this wrap, so CTC is not cleared.
         if (md.dual) begin
            if (s_q.dir == DIR_UP && s_q.cnt >= top) begin
               s_d.dir = DIR_DOWN;
               s_d.cnt = s_q.cnt - 16'h0001;
            end else if (s_q.dir == DIR_DOWN && at_bot) begin
               s_d.dir = DIR_UP;
               s_d.cnt = s_q.cnt + 16'h0001;
            end else if (s_q.dir == DIR_DOWN) begin
               s_d.cnt = s_q.cnt - 16'h0001;
            end else begin
               s_d.cnt = s_q.cnt + 16'h0001;
            end
         end else begin
            s_d.dir = DIR_UP;
            s_d.cnt = at_top ? CNT_BOTTOM : s_q.cnt + 16'h0001;
         end
      end
      if (upd_now) begin
         s_d.ocra = s_q.ocra_buf;
         s_d.ocrb = s_q.ocrb_buf;
      end
      if (cap_evt)
         s_d.icr = s_q.cnt;
      s_d.status = (s_q.status & ~st_clr) | st_set;
      if (s_q.dph_rd && s_q.dph_idx == IDX_CNT_L)
         s_d.temp = s_q.cnt[15:8];
      if (s_q.dph_rd && s_q.dph_idx == IDX_CAP_L)
         s_d.temp = s_q.icr[15:8];
      if (s_q.dph_wr) begin
         case (s_q.dph_idx)
            IDX_WAVE:   s_d.wave = wd;
            IDX_CAPCLK: s_d.capclk = wd;
            IDX_CNT_H, IDX_CAP_H, IDX_CMPA_H, IDX_CMPB_H:
               s_d.temp = wd;
            IDX_CNT_L: begin
               s_d.cnt   = {s_q.temp, wd};
               s_d.block = 1'b1;
            end
            IDX_CAP_L:  s_d.icr = {s_q.temp, wd};
            IDX_CMPA_L: s_d.ocra_buf = {s_q.temp, wd};
            IDX_CMPB_L: s_d.ocrb_buf = {s_q.temp, wd};
            IDX_MASK:   s_d.mask = wd[ST_W-1:0];
            default:    s_d.mask = s_q.mask;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q        <= '0;
         s_q.wave   <= REG_RESET;
         s_q.capclk <= REG_RESET;
         s_q.dir    <= DIR_UP;
      end else begin
         s_q <= s_d;
      end
   end

   always_comb begin
      case (s_q.dph_idx)
         IDX_WAVE:   rd = s_q.wave;
         IDX_CAPCLK: rd = s_q.capclk;
         IDX_FORCE:  rd = 8'h00;
         IDX_CNT_L:  rd = s_q.cnt[7:0];
         IDX_CAP_L:  rd = s_q.icr[7:0];
         IDX_CNT_H, IDX_CAP_H: rd = s_q.temp;
         IDX_CMPA_L: rd = s_q.ocra_buf[7:0];
         IDX_CMPA_H: rd = s_q.ocra_buf[15:8];
         IDX_CMPB_L: rd = s_q.ocrb_buf[7:0];
         IDX_CMPB_H: rd = s_q.ocrb_buf[15:8];
         IDX_STATUS: rd = {{(8-ST_W){1'b0}}, s_q.status};
         IDX_MASK:   rd = {{(8-ST_W){1'b0}}, s_q.mask};
         default:    rd = 8'h00;
      endcase
   end

   assign hrdata                = s_q.dph_rd ? {24'h00_0000, rd} : '0;
   assign hreadyout             = 1'b1;
   assign hresp                 = 1'b0;
   assign irq                   = |(s_q.status & s_q.mask);
   assign wave_evt_a            = s_q.evt_a;
   assign wave_evt_b            = s_q.evt_b;
   assign compare_output_mode_a = s_q.wave[7:6];
   assign compare_output_mode_b = s_q.wave[5:4];
   assign counter_value         = s_q.cnt;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_mode_low_bits: assert property ((s_q.dph_wr && s_q.dph_idx == IDX_WAVE) |=> wave_mode_sel[1:0] == $past(hwdata[1:0]))
      else $error("Mode low bits did not follow the write.");
   chk_fixed_top: assert property ((wave_mode_sel == 4'd7) |-> top == 16'h03FF)
      else $error("Fixed TOP wrong for 10-bit mode.");
   chk_top_source: assert property ((wave_mode_sel == 4'd14) |-> top == s_q.icr)
      else $error("TOP not taken from capture register.");
   chk_fast_ovf: assert property ((md.ovf == AT_TOP && tick && at_top && !s_q.block) |=> s_q.status[ST_OVF])
      else $error("Overflow flag not set at TOP.");
   chk_capture_copy: assert property (cap_evt |=> s_q.icr == $past(s_q.cnt) && s_q.status[ST_CAP])
      else $error("Capture did not copy counter and flag.");
   chk_no_cap_top: assert property ((md.src == TOP_CAP) |-> !cap_evt)
      else $error("Capture happened while capture register is TOP.");
   chk_force_no_flag: assert property ((force_a && !match_a && !s_q.status[ST_CMPA]) |=> !s_q.status[ST_CMPA] && s_q.evt_a)
      else $error("Forced match raised a flag or no event.");
   chk_force_reads_zero: assert property ((s_q.dph_rd && s_q.dph_idx == IDX_FORCE) |-> hrdata == 32'h0000_0000)
      else $error("Force register read not zero.");
   chk_write_blocks: assert property ((s_q.dph_wr && s_q.dph_idx == IDX_CNT_L) |=> !match_a until_with tick)
      else $error("Match not blocked after counter write.");
   chk_temp_pair: assert property ((s_q.dph_wr && s_q.dph_idx == IDX_CNT_L) |=> s_q.cnt == {$past(s_q.temp), $past(hwdata[7:0])})
      else $error("Counter write did not join latched high byte.");

   cov_capture: cover property (cap_evt ##1 irq);
   cov_forced: cover property (force_a ##1 wave_evt_a);
   cov_dual_turn: cover property (s_q.dir == DIR_UP ##1 s_q.dir == DIR_DOWN);
endmodule
`default_nettype wire

// *** inc/tmc_pkg.sv ***
// Register map, mode table and shared types of the timer control block.
// Contract
// - Mode select joins ctrl A[1:0], B[4:3].
// - Normal 0xFFFF; 8/9/10-bit modes fixed TOP.
// - Modes 4,9,11,15 compare A TOP; 8,10,12,14 capture.
// - Buffer update and overflow point follow mode.
// - Filter needs four equal samples to change.
// - Edge select: zero falling, one rising.
// - Capture copies counter, sets flag, interrupts.
// - Capture off while capture register is TOP.
// - Clock select 000 stops; 001 passes clock; 010-101 divide it.
// - Codes 110/111 count external pin edges.
// - Force strobe fires match in non-PWM modes.
// - Forced match: no interrupt, no CTC clear.
// - Force bits hold nothing, read zero.
// - Counter write blocks next timer-clock match.
// - Wide writes and counter/capture reads go through shared high-byte latch.
package tmc_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_WAVE   = 8'h90;
   localparam logic [7:0] IDX_CAPCLK = 8'h91;
   localparam logic [7:0] IDX_FORCE  = 8'h92;
   localparam logic [7:0] IDX_CNT_L  = 8'h94;
   localparam logic [7:0] IDX_CNT_H  = 8'h95;
   localparam logic [7:0] IDX_CAP_L  = 8'h96;
   localparam logic [7:0] IDX_CAP_H  = 8'h97;
   localparam logic [7:0] IDX_CMPA_L = 8'h98;
   localparam logic [7:0] IDX_CMPA_H = 8'h99;
   localparam logic [7:0] IDX_CMPB_L = 8'h9A;
   localparam logic [7:0] IDX_CMPB_H = 8'h9B;
   localparam logic [7:0] IDX_STATUS = 8'h9C;
   localparam logic [7:0] IDX_MASK   = 8'h9D;
   localparam logic [7:0] REG_RESET  = 8'h00;
   // Field positions.
   localparam int FLD_FILTER_EN = 7;
   localparam int FLD_EDGE_SEL  = 6;
   localparam int FLD_FORCE_A   = 7;
   localparam int FLD_FORCE_B   = 6;
   // Status and mask bit positions.
   localparam int ST_OVF  = 0;
   localparam int ST_CMPA = 1;
   localparam int ST_CMPB = 2;
   localparam int ST_CAP  = 3;
   localparam int ST_W    = 4;
   // Counter limits and fixed TOP values.
   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [15:0] CNT_MAX    = 16'hFFFF;
   localparam logic [15:0] TOP_8BIT   = 16'h00FF;
   localparam logic [15:0] TOP_9BIT   = 16'h01FF;
   localparam logic [15:0] TOP_10BIT  = 16'h03FF;
   // Prescaler divide masks and capture filter length.
   localparam logic [9:0] DIV8_MASK    = 10'h007;
   localparam logic [9:0] DIV64_MASK   = 10'h03F;
   localparam logic [9:0] DIV256_MASK  = 10'h0FF;
   localparam logic [9:0] DIV1024_MASK = 10'h3FF;
   localparam int         FILTER_LEN   = 4;

   typedef enum logic [1:0] {TOP_FIXED, TOP_CMPA, TOP_CAP} tmc_topsrc_t;
   typedef enum logic [1:0] {AT_IMM, AT_TOP, AT_BOTTOM, AT_MAX} tmc_at_t;
   typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} tmc_dir_t;

   typedef struct packed {
      logic        pwm;
      logic        dual;
      tmc_topsrc_t src;
      logic [15:0] fixed_top;
      tmc_at_t     upd;
      tmc_at_t     ovf;
   } tmc_mode_t;

   function automatic tmc_mode_t tmc_decode(input logic [3:0] m);
      tmc_mode_t r;
      r = '{1'b0, 1'b0, TOP_FIXED, CNT_MAX, AT_IMM, AT_MAX};
      case (m)
         4'd1, 4'd2, 4'd3: r = '{1'b1, 1'b1, TOP_FIXED, CNT_MAX, AT_TOP,
                                 AT_BOTTOM};
         4'd4:  r.src = TOP_CMPA;
         4'd5, 4'd6, 4'd7: r = '{1'b1, 1'b0, TOP_FIXED, CNT_MAX, AT_BOTTOM,
                                 AT_TOP};
         4'd8:  r = '{1'b1, 1'b1, TOP_CAP, CNT_MAX, AT_BOTTOM, AT_BOTTOM};
         4'd9:  r = '{1'b1, 1'b1, TOP_CMPA, CNT_MAX, AT_BOTTOM, AT_BOTTOM};
         4'd10: r = '{1'b1, 1'b1, TOP_CAP, CNT_MAX, AT_TOP, AT_BOTTOM};
         4'd11: r = '{1'b1, 1'b1, TOP_CMPA, CNT_MAX, AT_TOP, AT_BOTTOM};
         4'd12: r.src = TOP_CAP;
         4'd14: r = '{1'b1, 1'b0, TOP_CAP, CNT_MAX, AT_BOTTOM, AT_TOP};
         4'd15: r = '{1'b1, 1'b0, TOP_CMPA, CNT_MAX, AT_BOTTOM, AT_TOP};
         default: r.src = TOP_FIXED;
      endcase
      if (m[1:0] == 2'd1 && !m[3])
         r.fixed_top = TOP_8BIT;
      else if (m[1:0] == 2'd2 && !m[3])
         r.fixed_top = TOP_9BIT;
      else if (m[1:0] == 2'd3 && !m[3])
         r.fixed_top = TOP_10BIT;
      return r;
   endfunction
endpackage

// *** core/tmc_prescale.sv ***
// Clock source selection and prescaler that make the counter's tick.
`timescale 1ns/10ps
`default_nettype none
module tmc_prescale
   import tmc_pkg::*;
(
   input  wire logic       hclk,               // System clock.
   input  wire logic       hresetn,            // Async reset, active low.
   input  wire logic [2:0] count_clock_sel,    // Clock source code.
   input  wire logic       external_count_pin, // External count input.
   output logic            tick                // One-cycle count enable.
);
   logic [9:0] div_q;
   logic       pin_q;
   logic [9:0] mask;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= 10'h000;
         pin_q <= 1'b0;
      end else begin
         div_q <= div_q + 10'h001;
         pin_q <= external_count_pin;
      end
   end

   always_comb begin
      mask = DIV8_MASK;
      tick = 1'b0;
      case (count_clock_sel)
         3'b000: tick = 1'b0;
         3'b001: tick = 1'b1;
         3'b010: mask = DIV8_MASK;
         3'b011: mask = DIV64_MASK;
         3'b100: mask = DIV256_MASK;
         3'b101: mask = DIV1024_MASK;
         3'b110: tick = pin_q && !external_count_pin;
         3'b111: tick = !pin_q && external_count_pin;
         default: tick = 1'b0;
      endcase
      if (count_clock_sel inside {3'b010, 3'b011, 3'b100, 3'b101})
         tick = (div_q & mask) == mask;
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_clock_stopped: assert property (count_clock_sel == 3'b000 |-> !tick)
      else $error("Tick seen while clock is stopped.");
   chk_ext_rising: assert property ((count_clock_sel == 3'b111
      && $rose(external_count_pin)) |-> tick)
      else $error("Rising external edge did not tick.");
endmodule
`default_nettype wire

// *** core/tmc_capfilt.sv ***
// Capture input noise filter and edge detector.
`timescale 1ns/10ps
`default_nettype none
module tmc_capfilt
   import tmc_pkg::*;
#(
   parameter int LEN = FILTER_LEN // Equal samples needed to change.
) (
   input  wire logic hclk,              // System clock.
   input  wire logic hresetn,           // Async reset, active low.
   input  wire logic capture_input_pin, // Capture input.
   input  wire logic filter_en,         // Filter enable.
   input  wire logic edge_sel,          // One: rising, zero: falling.
   output logic      cap_evt            // One-cycle capture event.
);
   logic [LEN-1:0] smp_q;
   logic           filt_q;
   logic           prev_q;
   logic           filt_d;

   always_comb begin
      filt_d = capture_input_pin;
      if (filter_en) begin
         filt_d = filt_q;
         if (&smp_q)
            filt_d = 1'b1;
         else if (~|smp_q)
            filt_d = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         smp_q  <= '0;
         filt_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         smp_q  <= {smp_q[LEN-2:0], capture_input_pin};
         filt_q <= filt_d;
         prev_q <= filt_q;
      end
   end

   // The filter costs LEN cycles of delay on the capture moment.
   assign cap_evt = edge_sel ? (filt_q && !prev_q) : (!filt_q && prev_q);

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_filter_hold: assert property ((filter_en && $past(filter_en)
      && filt_q != $past(filt_q)) |-> $past(&smp_q) || $past(~|smp_q))
      else $error("Filtered input changed without equal samples.");
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the timer control block over its register bus.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import tmc_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, cap_pin, ext_pin, rd_ph;
   logic        hreadyout, hresp, irq, wave_evt_a, wave_evt_b;
   logic [1:0]  htrans, cm_a, cm_b;
   logic [2:0]  hsize;
   logic [3:0]  wave_mode_sel;
   logic [15:0] counter_value, rnd, v;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0]  exp_q[$];
   int          fail_count, compares, evt_a, evt_b, ea0, eb0;

   tmc_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .capture_input_pin(cap_pin),
      .external_count_pin(ext_pin), .irq(irq), .wave_evt_a(wave_evt_a),
      .wave_evt_b(wave_evt_b), .compare_output_mode_a(cm_a),
      .compare_output_mode_b(cm_b), .counter_value(counter_value),
      .wave_mode_sel(wave_mode_sel));

   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic fail(input string msg);
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask

   task automatic chk_rd(input logic [31:0] got, input logic [7:0] e);
      compares++;
      if (got !== {24'h00_0000, e})
         fail($sformatf("read %h, expected %h", got, e));
   endtask

   task automatic chk_lvl(input logic [3:0] got, input logic [3:0] e);
      compares++;
      if (got !== e)
         fail($sformatf("level %h, expected %h", got, e));
   endtask

   // Address phase held until ready, then data phase held until ready.
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {22'h00_0000, idx, 2'b00};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b0, idx, 8'h00);
   endtask

   // High byte first on writes, low byte first on reads.
   task automatic wr16(input logic [7:0] idx, input logic [15:0] d);
      wr(idx + 8'h01, d[15:8]);
      wr(idx, d[7:0]);
   endtask

   task automatic rd16(input logic [7:0] idx, input logic [15:0] e);
      rd(idx, e[7:0]);
      rd(idx + 8'h01, e[15:8]);
   endtask

   task automatic cfg(input logic [7:0] w, input logic [7:0] c);
      wr(IDX_WAVE, w);
      wr(IDX_CAPCLK, c);
   endtask

   task automatic clr;
      wr(IDX_STATUS, 8'h0f);
   endtask

   task automatic pulses(input int n);
      repeat (n) begin
         ext_pin <= 1'b1;
         repeat (3) @(posedge hclk);
         ext_pin <= 1'b0;
         repeat (3) @(posedge hclk);
      end
   endtask

   task automatic cap(input logic l, input int n);
      cap_pin <= l;
      repeat (n) @(posedge hclk);
   endtask

   task automatic irq_is(input logic e);
      @(negedge hclk);
      chk_lvl({3'b000, irq}, {3'b000, e});
   endtask

   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Read data is judged in the data phase against the oldest note.
   always @(posedge hclk) begin
      if (rd_ph) begin
         if (exp_q.size() == 0)
            fail("read without expectation");
         else
            chk_rd(hrdata, exp_q.pop_front());
      end
      rd_ph <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
      if (wave_evt_a === 1'b1) evt_a++;
      if (wave_evt_b === 1'b1) evt_b++;
   end

   initial begin
      repeat (20000) @(posedge hclk);
      fail("watchdog expired");
      test_done;
   end

   initial begin
      {hresetn, hsel, hwrite, cap_pin, ext_pin} = '0;
      htrans = 2'b00;
      hsize = 3'h2;
      haddr = '0;
      hwdata = '0;
      rnd = 16'hf136;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      wr(8'h93, 8'hff);
      for (int i = 'h90; i < 'ha0; i++) rd(8'(i), 8'h00);
      $display("test reset done");
      for (int m = 0; m < 16; m++) begin
         cfg(8'h90 | 8'(m & 3), 8'((m >> 2) << 3));
         @(negedge hclk);
         chk_lvl(wave_mode_sel, 4'(m));
         chk_lvl({cm_a, cm_b}, 4'h9);
      end
      rd(IDX_CAPCLK, 8'h18);
      $display("test modes done");
      cfg(8'h00, 8'h00);
      wr16(IDX_CMPA_L, 16'h8000);
      wr16(IDX_CMPB_L, 16'h8000);
      wr16(IDX_CNT_L, 16'hfffe);
      repeat (20) @(posedge hclk);
      rd16(IDX_CNT_L, 16'hfffe);
      clr;
      wr(IDX_MASK, 8'h01);
      wr(IDX_CAPCLK, 8'h07);
      pulses(2);
      wr(IDX_CAPCLK, 8'h00);
      rd16(IDX_CNT_L, 16'h0000);
      rd(IDX_STATUS, 8'h01);
      irq_is(1'b1);
      wr(IDX_MASK, 8'h00);
      irq_is(1'b0);
      wr(IDX_MASK, 8'h01);
      wr(IDX_STATUS, 8'h01);
      irq_is(1'b0);
      cfg(8'h01, 8'h08);
      wr16(IDX_CNT_L, 16'h00fe);
      clr;
      wr(IDX_CAPCLK, 8'h0f);
      pulses(2);
      wr(IDX_CAPCLK, 8'h08);
      rd16(IDX_CNT_L, 16'h0000);
      rd(IDX_STATUS, 8'h01);
      wr(IDX_CAPCLK, 8'h00);
      wr16(IDX_CNT_L, 16'h00fe);
      clr;
      wr(IDX_CAPCLK, 8'h07);
      pulses(3);
      wr(IDX_CAPCLK, 8'h00);
      rd(IDX_STATUS, 8'h00);
      rd16(IDX_CNT_L, 16'h00fd);
      cfg(8'h00, 8'h08);
      wr16(IDX_CMPA_L, 16'h0003);
      wr16(IDX_CNT_L, 16'h0000);
      clr;
      wr(IDX_CAPCLK, 8'h0f);
      pulses(4);
      wr(IDX_CAPCLK, 8'h08);
      rd16(IDX_CNT_L, 16'h0000);
      rd(IDX_STATUS, 8'h02);
      wr(IDX_CAPCLK, 8'h18);
      wr16(IDX_CAP_L, 16'h0002);
      wr16(IDX_CNT_L, 16'h0000);
      wr(IDX_CAPCLK, 8'h1f);
      pulses(3);
      wr(IDX_CAPCLK, 8'h58);
      rd16(IDX_CNT_L, 16'h0000);
      clr;
      cap(1'b1, 8);
      rd(IDX_STATUS, 8'h00);
      rd16(IDX_CAP_L, 16'h0002);
      cap(1'b0, 8);
      $display("test counting done");
      cfg(8'h00, 8'h08);
      wr16(IDX_CNT_L, 16'h0001);
      clr;
      wr(IDX_MASK, 8'h0f);
      ea0 = evt_a;
      eb0 = evt_b;
      wr(IDX_FORCE, 8'hc0);
      repeat (3) @(posedge hclk);
      chk_lvl(4'(evt_a - ea0), 4'h1);
      chk_lvl(4'(evt_b - eb0), 4'h1);
      irq_is(1'b0);
      rd(IDX_STATUS, 8'h00);
      rd16(IDX_CNT_L, 16'h0001);
      rd(IDX_FORCE, 8'h00);
      wr(IDX_WAVE, 8'h01);
      ea0 = evt_a;
      wr(IDX_FORCE, 8'hc0);
      repeat (3) @(posedge hclk);
      chk_lvl(4'(evt_a - ea0), 4'h0);
      cfg(8'h00, 8'h00);
      wr16(IDX_CMPA_L, 16'h0010);
      wr16(IDX_CNT_L, 16'h0010);
      clr;
      wr(IDX_CAPCLK, 8'h07);
      pulses(1);
      wr(IDX_CAPCLK, 8'h06);
      pulses(2);
      wr(IDX_CAPCLK, 8'h00);
      rd(IDX_STATUS, 8'h00);
      rd16(IDX_CNT_L, 16'h0013);
      // Eighty cycles at divide by eight give ten ticks in any phase.
      wr16(IDX_CNT_L, 16'h0000);
      wr(IDX_CAPCLK, 8'h02);
      repeat (77) @(posedge hclk);
      wr(IDX_CAPCLK, 8'h00);
      rd16(IDX_CNT_L, 16'h000a);
      chk_lvl(counter_value[3:0], 4'ha);
      chk_lvl({3'b000, hresp}, 4'h0);
      $display("test force done");
      wr(IDX_CAPCLK, 8'h40);
      rnd = lfsr(rnd);
      v = rnd;
      wr16(IDX_CNT_L, v);
      clr;
      wr(IDX_MASK, 8'h08);
      cap(1'b1, 6);
      irq_is(1'b1);
      rd16(IDX_CAP_L, v);
      rnd = lfsr(rnd);
      v = rnd;
      wr16(IDX_CNT_L, v);
      wr(IDX_CAPCLK, 8'h00);
      clr;
      cap(1'b0, 6);
      rd(IDX_STATUS, 8'h08);
      rd16(IDX_CAP_L, v);
      clr;
      cap(1'b1, 6);
      rd(IDX_STATUS, 8'h00);
      wr(IDX_CAPCLK, 8'hc0);
      cap(1'b0, 8);
      clr;
      cap(1'b1, 3);
      cap(1'b0, 8);
      rd(IDX_STATUS, 8'h00);
      cap(1'b1, 8);
      rd(IDX_STATUS, 8'h08);
      $display("test capture done");
      test_done;
   end
endmodule
`default_nettype wire
